// File: logic/usbrb_regs.svh
// Register offsets, bit positions, reset values and timing counts
// Assumes a 10 MHz system clock; included by bare name
`ifndef USBRB_REGS_SVH
`define USBRB_REGS_SVH

// CPU register offsets
`define USBRB_A_DEVCTL  4'h0
`define USBRB_A_EVFLG   4'h1
`define USBRB_A_EVEN    4'h2
`define USBRB_A_ADDR    4'h3
`define USBRB_A_FNH     4'h4
`define USBRB_A_FNL     4'h5
`define USBRB_A_FERR    4'h6
`define USBRB_A_EPSEL   4'h7
`define USBRB_A_ENDPOINT_FIFO_CLEAR   4'h8
`define USBRB_A_EPCTL   4'h9
`define USBRB_A_EPCFG0  4'hA
`define USBRB_A_EPCFG1  4'hB
`define USBRB_A_EPSTA   4'hC

// Device control bits
`define USBRB_B_CPU_RESET_ON_BUS_RESET  3
`define USBRB_B_LSM     2
`define USBRB_B_RMWK    1
`define USBRB_B_DETACH  0
// Event flag and enable bits
`define USBRB_F_HRES    6
`define USBRB_F_REND    5
`define USBRB_F_WAKE    4
`define USBRB_F_RSTEND  3
`define USBRB_F_SOF     2
`define USBRB_F_IDLE    0
`define USBRB_EV_MASK   8'h7D
`define USBRB_EVEN_RST  8'h08
// Address, frame and endpoint bits
`define USBRB_B_ADDRESS_VALID   7
`define USBRB_B_FRAME_INDEX_CRC_ERROR  4
`define USBRB_B_STALL   5
`define USBRB_B_STALLC  4
`define USBRB_B_TOGRST  3
`define USBRB_B_ENDPOINT_ACTIVE    0
`define USBRB_B_TRANSFER_DIRECTION   0
`define USBRB_B_RESERVE_ENDPOINT_MEMORY   1
`define USBRB_B_CONFIGURATION_VALID   7
`define USBRB_EP_NONE   3'h7
`define USBRB_SIZE_RSV  3'h7

// Timing: times in their own unit, counts derived from the clock rate
`define USBRB_CLK_KHZ     10000
`define USBRB_SUSP_MS     3
`define USBRB_RESUME_MS   2
`define USBRB_FRAME_MS    1
`define USBRB_BRST_US     100
`define USBRB_SUSP_CYC    (`USBRB_SUSP_MS * `USBRB_CLK_KHZ)
`define USBRB_RESUME_CYC  (`USBRB_RESUME_MS * `USBRB_CLK_KHZ)
`define USBRB_FRAME_CYC   (`USBRB_FRAME_MS * `USBRB_CLK_KHZ)
`define USBRB_BRST_CYC    (`USBRB_BRST_US * `USBRB_CLK_KHZ / 1000)
`define USBRB_FIFO_BYTES  512

`endif

// File: logic/usbrb_pkg.sv
// Types shared by both ends of the USB register bank
// Assumes nothing beyond a SystemVerilog compiler
package usbrb_pkg;
  // Upstream resume sequencer states
  typedef enum logic [1:0] {
    USBRB_RS_IDLE = 2'b01,
    USBRB_RS_SIG  = 2'b10
  } usbrb_rs_e;
  // Endpoint transfer type encoding
  typedef enum logic [1:0] {
    USBRB_TT_CTRL = 2'b00,
    USBRB_TT_ISO  = 2'b01,
    USBRB_TT_BULK = 2'b10,
    USBRB_TT_INT  = 2'b11
  } usbrb_tt_e;
  typedef logic [10:0] usbrb_frame_t;
endpackage

// File: logic/usbrb_link_if.sv
// Abstract USB line between host end and device end
// Assumes both ends run on one sys_clk
`timescale 1ns/1ps
`default_nettype none
interface usbrb_link_if;
  import usbrb_pkg::*;
  logic         bus_reset;       // Host holds SE0 reset
  logic         host_resume;     // Host drives resume K
  logic         line_busy;       // Non-idle traffic on the line
  logic         sof_stb;         // SOF token received, one cycle
  usbrb_frame_t sof_frame;       // Frame number of that SOF
  logic         sof_crc_err;     // SOF frame number corrupted
  logic         setup_stb;       // SETUP token, one cycle
  logic [2:0]   setup_ep;        // Endpoint of that SETUP
  logic         dp_pullup;       // Device D+ pull-up on
  logic         dm_pullup;       // Device D- pull-up on
  logic         upstream_resume; // Device drives resume
  logic [6:0]   dev_addr;        // Device address
  logic         addr_valid;      // Address in use
  logic [6:0]   ep_stall;        // Endpoint answers STALL
  logic [6:0]   ep_enabled;      // Endpoint enabled
  logic [6:0]   toggle_clear;    // Data toggle forced to 0, pulse

  modport dev (
    input  bus_reset, host_resume, line_busy, sof_stb, sof_frame,
           sof_crc_err, setup_stb, setup_ep,
    output dp_pullup, dm_pullup, upstream_resume, dev_addr,
           addr_valid, ep_stall, ep_enabled, toggle_clear
  );
  modport host (
    output bus_reset, host_resume, line_busy, sof_stb, sof_frame,
           sof_crc_err, setup_stb, setup_ep,
    input  dp_pullup, dm_pullup, upstream_resume, dev_addr,
           addr_valid, ep_stall, ep_enabled, toggle_clear
  );
endinterface
`default_nettype wire

// File: logic/usbrb_flag.sv
// Sticky flag vector: hardware set wins over clear
// Assumes set and clear come from sys_clk logic
`timescale 1ns/1ps
`default_nettype none
module usbrb_flag
  import usbrb_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         sys_clk, // System clock
  input  wire logic         nrst,    // Async reset, active low
  input  wire logic [W-1:0] set,     // Set per bit
  input  wire logic [W-1:0] clr,     // Clear per bit
  output logic      [W-1:0] q        // Flag state
);
  // Set has priority so no event is lost
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= set | (q & ~clr);
    end
  end
endmodule
`default_nettype wire

// File: logic/usbrb_device.sv
// Device end: device and endpoint registers of a USB device controller
// Assumes a CPU port on sys_clk and a host end on the same clock
`include "usbrb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module usbrb_device
  import usbrb_pkg::*;
#(
  parameter int SUSP_CYCLES   = `USBRB_SUSP_CYC,
  parameter int RESUME_CYCLES = `USBRB_RESUME_CYC,
  parameter int FIFO_BYTES    = `USBRB_FIFO_BYTES
) (
  input  wire logic       sys_clk,       // System clock, 10 MHz
  input  wire logic       nrst,          // Async reset, active low
  input  wire logic       usb_enable,    // Controller enabled
  input  wire logic       host_mode,     // Controller in host mode
  input  wire logic [3:0] cpu_addr,      // Register offset
  input  wire logic       cpu_wr,        // Write strobe
  input  wire logic       cpu_rd,        // Read strobe
  input  wire logic [7:0] cpu_wdata,     // Write data
  output logic      [7:0] cpu_rdata,     // Read data, next cycle
  output logic            usb_irq,       // General USB interrupt
  output logic            cpu_reset_req, // CPU reset pulse
  output logic      [6:0] ep_fifo_hold,  // Endpoint FIFOs in reset
  usbrb_link_if.dev       link           // USB line side
);
  // Write decodes
  wire wr_devctl = cpu_wr && (cpu_addr == `USBRB_A_DEVCTL);
  wire wr_evflg  = cpu_wr && (cpu_addr == `USBRB_A_EVFLG);
  wire wr_even   = cpu_wr && (cpu_addr == `USBRB_A_EVEN);
  wire wr_addr   = cpu_wr && (cpu_addr == `USBRB_A_ADDR);
  wire wr_epsel  = cpu_wr && (cpu_addr == `USBRB_A_EPSEL);
  wire wr_endpoint_fifo_clear  = cpu_wr && (cpu_addr == `USBRB_A_ENDPOINT_FIFO_CLEAR);
  wire wr_epctl  = cpu_wr && (cpu_addr == `USBRB_A_EPCTL);
  wire wr_epcfg0 = cpu_wr && (cpu_addr == `USBRB_A_EPCFG0);
  wire wr_epcfg1 = cpu_wr && (cpu_addr == `USBRB_A_EPCFG1);

  logic            cpu_reset_on_bus_reset_r, lsm_r, detach_r, rmw_req_r;
  logic      [7:0] even_r;
  logic      [6:0] addr_r;
  usbrb_frame_t    frame_r;
  logic            crcerr_r;
  logic      [2:0] epsel_r;
  logic      [6:0] endpoint_fifo_clear_r, endpoint_active_r, transfer_direction_r, reserve_endpoint_memory_r, configuration_valid_r, tog_r;
  logic      [1:0] transfer_type_r [7];
  logic      [2:0] buffer_size_code_r [7];
  logic      [1:0] epbank_r [7];
  logic            brst_d_r, hres_d_r, busy_d_r;
  logic     [31:0] idle_cnt_r, rs_cnt_r;
  usbrb_rs_e       rs_r;
  logic      [7:0] ev_q;
  logic      [6:0] stall_q;
  logic            addr_valid_q;

  // Line event detection
  wire rst_end  = brst_d_r && !link.bus_reset;
  wire rsm_end  = hres_d_r && !link.host_resume;
  wire line_act = link.bus_reset || link.host_resume || link.line_busy;
  wire act_rise = line_act && !(brst_d_r || hres_d_r || busy_d_r);
  wire sending  = (rs_r == USBRB_RS_SIG);
  wire wake_det = act_rise && ev_q[`USBRB_F_IDLE] && !sending;
  wire line_idle = !line_act && !sending;
  wire idle_hit = line_idle && (idle_cnt_r == 32'(SUSP_CYCLES - 1));
  wire rs_start = (rs_r == USBRB_RS_IDLE) && rmw_req_r;
  wire rs_done  = sending && (rs_cnt_r == 32'(RESUME_CYCLES - 1));

  // Event flag set and software clear vectors
  wire [7:0] ev_set = {1'b0, rs_start, rsm_end, wake_det, rst_end,
                       link.sof_stb, 1'b0, idle_hit};
  wire [7:0] ev_clr = wr_evflg ? (~cpu_wdata & `USBRB_EV_MASK)
                               : 8'h00;

  usbrb_flag #(.W(8)) u_events (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set     (ev_set),
    .clr     (ev_clr),
    .q       (ev_q)
  );

  // Address enable: software sets, hardware clears at bus reset end
  wire addr_set = wr_addr && cpu_wdata[`USBRB_B_ADDRESS_VALID];
  usbrb_flag #(.W(1)) u_addren (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set     (addr_set),
    .clr     (rst_end),
    .q       (addr_valid_q)
  );

  // Endpoint selection and stall handling
  wire       ep_ok  = (epsel_r != `USBRB_EP_NONE);
  wire [6:0] ep_sel = ep_ok ? (7'h01 << epsel_r) : 7'h00;
  wire [6:0] setup_sel = link.setup_stb ? (7'h01 << link.setup_ep)
                                        : 7'h00;
  wire [6:0] stall_set = (wr_epctl && cpu_wdata[`USBRB_B_STALL])
                         ? ep_sel : 7'h00;
  wire [6:0] stall_cnc = (wr_epctl && cpu_wdata[`USBRB_B_STALLC])
                         ? ep_sel : 7'h00;
  usbrb_flag #(.W(7)) u_stall (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set     (stall_set),
    .clr     (setup_sel | stall_cnc),
    .q       (stall_q)
  );

  // Size and bank check against FIFO capacity
  wire [2:0]  nsize = cpu_wdata[6:4];
  wire [1:0]  nbank = cpu_wdata[3:2];
  wire [11:0] nbytes = 12'h008 << nsize;
  wire [12:0] nneed  = {1'b0, nbytes} << nbank[0];
  wire        fits   = (nsize != `USBRB_SIZE_RSV) && !nbank[1] &&
                       (nneed <= 13'(FIFO_BYTES));

  // Device control register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_reset_on_bus_reset_r <= 1'b0;
      lsm_r    <= 1'b0;
      detach_r <= 1'b1;
    end else begin
      if (!usb_enable) begin
        cpu_reset_on_bus_reset_r <= 1'b0;
      end else if (wr_devctl) begin
        cpu_reset_on_bus_reset_r <= cpu_wdata[`USBRB_B_CPU_RESET_ON_BUS_RESET];
      end
      if (wr_devctl) begin
        lsm_r    <= cpu_wdata[`USBRB_B_LSM];
        detach_r <= cpu_wdata[`USBRB_B_DETACH];
      end
    end
  end

  // Remote wake request and upstream resume sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rmw_req_r <= 1'b0;
      rs_r      <= USBRB_RS_IDLE;
      rs_cnt_r  <= '0;
    end else begin
      if (rs_done) begin
        rmw_req_r <= 1'b0;
      end else if (wr_devctl && cpu_wdata[`USBRB_B_RMWK] &&
                   ev_q[`USBRB_F_IDLE]) begin
        rmw_req_r <= 1'b1;
      end
      unique case (rs_r)
        USBRB_RS_IDLE: begin
          rs_cnt_r <= '0;
          if (rmw_req_r) begin
            rs_r <= USBRB_RS_SIG;
          end
        end
        USBRB_RS_SIG: begin
          rs_cnt_r <= rs_cnt_r + 32'd1;
          if (rs_done) begin
            rs_r <= USBRB_RS_IDLE;
          end
        end
        default: rs_r <= USBRB_RS_IDLE;
      endcase
    end
  end

  // Line history, idle counter, CPU reset pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      brst_d_r      <= 1'b0;
      hres_d_r      <= 1'b0;
      busy_d_r      <= 1'b0;
      idle_cnt_r    <= '0;
      cpu_reset_req <= 1'b0;
    end else begin
      brst_d_r      <= link.bus_reset;
      hres_d_r      <= link.host_resume;
      busy_d_r      <= link.line_busy;
      cpu_reset_req <= rst_end && cpu_reset_on_bus_reset_r && usb_enable;
      if (!line_idle || ev_q[`USBRB_F_IDLE]) begin
        idle_cnt_r <= '0;
      end else begin
        idle_cnt_r <= idle_cnt_r + 32'd1;
      end
    end
  end

  // Enables, address, frame number, endpoint selection
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      even_r   <= `USBRB_EVEN_RST;
      addr_r   <= '0;
      frame_r  <= '0;
      crcerr_r <= 1'b0;
      epsel_r  <= '0;
      endpoint_fifo_clear_r  <= '0;
      tog_r    <= '0;
    end else begin
      if (wr_even) begin
        even_r <= cpu_wdata & `USBRB_EV_MASK;
      end
      if (wr_addr) begin
        addr_r <= cpu_wdata[6:0];
      end
      if (link.sof_stb) begin
        frame_r  <= link.sof_frame;
        crcerr_r <= link.sof_crc_err;
      end
      if (wr_epsel) begin
        epsel_r <= cpu_wdata[2:0];
      end
      if (wr_endpoint_fifo_clear) begin
        endpoint_fifo_clear_r <= cpu_wdata[6:0];
      end
      tog_r <= (wr_epctl && cpu_wdata[`USBRB_B_TOGRST])
               ? ep_sel : 7'h00;
    end
  end

  // Per-endpoint configuration of the selected endpoint
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      endpoint_active_r  <= '0;
      transfer_direction_r <= '0;
      reserve_endpoint_memory_r <= '0;
      configuration_valid_r <= '0;
      for (int i = 0; i < 7; i++) begin
        transfer_type_r[i] <= USBRB_TT_CTRL;
        buffer_size_code_r[i] <= '0;
        epbank_r[i] <= '0;
      end
    end else if (ep_ok) begin
      if (wr_epctl) begin
        endpoint_active_r[epsel_r] <= cpu_wdata[`USBRB_B_ENDPOINT_ACTIVE];
      end
      if (wr_epcfg0) begin
        transfer_type_r[epsel_r] <= cpu_wdata[7:6];
        transfer_direction_r[epsel_r]  <= cpu_wdata[`USBRB_B_TRANSFER_DIRECTION];
      end
      if (wr_epcfg1) begin
        buffer_size_code_r[epsel_r] <= nsize;
        epbank_r[epsel_r] <= nbank;
        reserve_endpoint_memory_r[epsel_r]  <= cpu_wdata[`USBRB_B_RESERVE_ENDPOINT_MEMORY];
        configuration_valid_r[epsel_r]  <= cpu_wdata[`USBRB_B_RESERVE_ENDPOINT_MEMORY] && fits;
      end
    end
  end

  // Read selection
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (cpu_addr)
      `USBRB_A_DEVCTL: rd_mux = {4'h0, cpu_reset_on_bus_reset_r, lsm_r, rmw_req_r,
                                 detach_r};
      `USBRB_A_EVFLG:  rd_mux = ev_q;
      `USBRB_A_EVEN:   rd_mux = even_r;
      `USBRB_A_ADDR:   rd_mux = {addr_valid_q, addr_r};
      `USBRB_A_FNH:    rd_mux = {5'h00, frame_r[10:8]};
      `USBRB_A_FNL:    rd_mux = frame_r[7:0];
      `USBRB_A_FERR:   rd_mux = {3'h0, crcerr_r, 4'h0};
      `USBRB_A_EPSEL:  rd_mux = {5'h00, epsel_r};
      `USBRB_A_ENDPOINT_FIFO_CLEAR:  rd_mux = {1'b0, endpoint_fifo_clear_r};
      `USBRB_A_EPCTL:  rd_mux = ep_ok ? {2'h0, stall_q[epsel_r], 4'h0,
                                         endpoint_active_r[epsel_r]} : 8'h00;
      `USBRB_A_EPCFG0: rd_mux = ep_ok ? {transfer_type_r[epsel_r], 5'h00,
                                         transfer_direction_r[epsel_r]} : 8'h00;
      `USBRB_A_EPCFG1: rd_mux = ep_ok ? {1'b0, buffer_size_code_r[epsel_r],
                                         epbank_r[epsel_r],
                                         reserve_endpoint_memory_r[epsel_r], 1'b0}
                                      : 8'h00;
      `USBRB_A_EPSTA:  rd_mux = ep_ok ? {configuration_valid_r[epsel_r], 7'h00}
                                      : 8'h00;
      default:         rd_mux = 8'h00;
    endcase
  end

  // Read data register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata <= rd_mux;
    end
  end

  // Outputs toward the CPU and the line
  wire pullup_connect_ok = usb_enable && !host_mode && !detach_r;
  assign usb_irq           = |(ev_q & even_r);
  assign ep_fifo_hold      = endpoint_fifo_clear_r;
  assign link.dp_pullup    = pullup_connect_ok && !lsm_r;
  assign link.dm_pullup    = pullup_connect_ok && lsm_r;
  assign link.upstream_resume = sending;
  assign link.dev_addr     = addr_r;
  assign link.addr_valid   = addr_valid_q;
  assign link.ep_stall     = stall_q & endpoint_active_r;
  assign link.ep_enabled   = endpoint_active_r;
  assign link.toggle_clear = tog_r;
endmodule
`default_nettype wire

// File: logic/usbrb_host.sv
// Host end: drives bus reset, resume, SOF and SETUP onto the line
// Assumes commands arrive as one-cycle pulses on sys_clk
`include "usbrb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module usbrb_host
  import usbrb_pkg::*;
#(
  parameter int FRAME_CYCLES = `USBRB_FRAME_CYC,
  parameter int RESET_CYCLES = `USBRB_BRST_CYC,
  parameter int RSM_CYCLES   = `USBRB_RESUME_CYC
) (
  input  wire logic       sys_clk,     // System clock
  input  wire logic       nrst,        // Async reset, active low
  input  wire logic       cmd_reset,   // Start a bus reset, pulse
  input  wire logic       cmd_resume,  // Start a host resume, pulse
  input  wire logic       sof_enable,  // Send SOF every frame
  input  wire logic       crc_inject,  // Mark next SOF corrupted
  input  wire logic       cmd_setup,   // Send a SETUP, pulse
  input  wire logic [2:0] setup_ep_in, // Endpoint for that SETUP
  output logic            wake_seen,   // Device resume started, pulse
  output logic            dev_present, // Some pull-up present
  output logic            dev_low_spd, // D- pull-up present
  usbrb_link_if.host      link         // USB line side
);
  logic [31:0]  rst_cnt_r, rsm_cnt_r, frm_cnt_r;
  logic         brst_r, hres_r, sof_r, crc_r, setup_r, upr_d_r;
  logic [2:0]   sep_r;
  usbrb_frame_t frame_r;

  wire quiet     = !brst_r && !hres_r;
  wire frame_end = (frm_cnt_r == 32'(FRAME_CYCLES - 1));

  // Reset and resume signalling
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      brst_r    <= 1'b0;
      hres_r    <= 1'b0;
      rst_cnt_r <= '0;
      rsm_cnt_r <= '0;
    end else begin
      if (cmd_reset && !brst_r) begin
        brst_r    <= 1'b1;
        rst_cnt_r <= '0;
      end else if (brst_r) begin
        rst_cnt_r <= rst_cnt_r + 32'd1;
        brst_r    <= (rst_cnt_r != 32'(RESET_CYCLES - 1));
      end
      if (cmd_resume && quiet) begin
        hres_r    <= 1'b1;
        rsm_cnt_r <= '0;
      end else if (hres_r) begin
        rsm_cnt_r <= rsm_cnt_r + 32'd1;
        hres_r    <= (rsm_cnt_r != 32'(RSM_CYCLES - 1));
      end
    end
  end

  // Frame timer, SOF and SETUP tokens
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      frm_cnt_r <= '0;
      frame_r   <= '0;
      sof_r     <= 1'b0;
      crc_r     <= 1'b0;
      setup_r   <= 1'b0;
      sep_r     <= '0;
      upr_d_r   <= 1'b0;
      wake_seen <= 1'b0;
    end else begin
      upr_d_r   <= link.upstream_resume;
      wake_seen <= link.upstream_resume && !upr_d_r;
      frm_cnt_r <= (frame_end || !sof_enable) ? 32'd0
                                              : frm_cnt_r + 32'd1;
      sof_r     <= frame_end && sof_enable && quiet;
      if (crc_inject) begin
        crc_r <= 1'b1;
      end else if (sof_r) begin
        crc_r <= 1'b0;
      end
      if (sof_r) begin
        frame_r <= frame_r + 11'd1;
      end
      setup_r <= cmd_setup && quiet && (setup_ep_in != `USBRB_EP_NONE);
      if (cmd_setup) begin
        sep_r <= setup_ep_in;
      end
    end
  end

  // Line drive and device observation
  assign link.bus_reset   = brst_r;
  assign link.host_resume = hres_r;
  assign link.line_busy   = sof_r || setup_r;
  assign link.sof_stb     = sof_r;
  assign link.sof_frame   = frame_r;
  assign link.sof_crc_err = crc_r;
  assign link.setup_stb   = setup_r;
  assign link.setup_ep    = sep_r;
  assign dev_present      = link.dp_pullup || link.dm_pullup;
  assign dev_low_spd      = link.dm_pullup;
endmodule
`default_nettype wire

// File: verif/usbrb_checker.sv
// Assertions on the link joining host end and device end
// Assumes one sys_clk domain; placed beside the link interface
`timescale 1ns/1ps
`default_nettype none
module usbrb_checker
  import usbrb_pkg::*;
#(
  parameter int RESUME_CYCLES = 20
) (
  input wire logic       sys_clk,         // System clock
  input wire logic       nrst,            // Reset, active low
  input wire logic       bus_reset,       // Host bus reset
  input wire logic       sof_stb,         // SOF token
  input wire logic       sof_crc_err,     // SOF corrupted
  input wire logic       setup_stb,       // SETUP token
  input wire logic [2:0] setup_ep,        // SETUP endpoint
  input wire logic       dp_pullup,       // D+ pull-up
  input wire logic       dm_pullup,       // D- pull-up
  input wire logic       upstream_resume, // Device resume
  input wire logic       addr_valid,      // Address in use
  input wire logic [6:0] ep_stall,        // Stalled endpoints
  input wire logic [6:0] ep_enabled,      // Enabled endpoints
  input wire logic [6:0] toggle_clear     // Toggle reset pulses
);
  logic [15:0] rcnt_r; // Length of current resume
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Count cycles of upstream resume
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      rcnt_r <= 16'h0000;
    else
      rcnt_r <= upstream_resume ? rcnt_r + 16'h0001 : 16'h0000;
  end
  // Line relations
  chk_pullup_single: assert property (!(dp_pullup && dm_pullup))
    else $error("Both pull-ups on");
  chk_addr_cleared: assert property ($fell(bus_reset) |-> ##[1:2] !addr_valid)
    else $error("Address kept after bus reset");
  chk_resume_hold: assert property ($rose(upstream_resume) |-> upstream_resume[*8])
    else $error("Resume too short");
  chk_resume_bound: assert property (rcnt_r <= RESUME_CYCLES)
    else $error("Resume too long");
  chk_stall_enabled: assert property ((ep_stall & ~ep_enabled) == 7'h00)
    else $error("Stall on disabled endpoint");
  chk_setup_unstall: assert property (setup_stb |=> !ep_stall[$past(setup_ep)])
    else $error("Stall kept after SETUP");
  chk_toggle_single: assert property ($onehot0(toggle_clear))
    else $error("Several toggle resets");
  chk_sof_pulse: assert property (sof_stb |=> !sof_stb)
    else $error("SOF longer than a cycle");
  chk_setup_target: assert property (setup_stb |-> setup_ep != 3'h7)
    else $error("SETUP to endpoint seven");
  cov_resume: cover property ($rose(upstream_resume));
  cov_crc: cover property (sof_stb && sof_crc_err);
  cov_setup: cover property (setup_stb);
endmodule
`default_nettype wire

// File: verif/test_usb_device_register_bank.sv
// Bench joining host and device ends, driving the CPU port
// Assumes 10 MHz sys_clk and shortened suspend, frame and reset counts
`timescale 1ns/1ps
`default_nettype none
module test_usb_device_register_bank;
  import usbrb_pkg::*;
  logic       sys_clk, nrst, usb_enable, host_mode, cpu_wr, cpu_rd;
  logic       cmd_reset, cmd_resume, sof_enable, crc_inject, cmd_setup;
  logic       usb_irq, cpu_reset_req, wake_seen, dev_present, dev_low_spd;
  logic [3:0] cpu_addr;
  logic [2:0] setup_ep_in;
  logic [6:0] ep_fifo_hold, tog_seen;
  logic [7:0] cpu_wdata, cpu_rdata;
  int         bad_count, checked, n, s, b;
  usbrb_link_if link ();
  usbrb_device #(.SUSP_CYCLES(50), .RESUME_CYCLES(20)) u_usbrb_device (
    .sys_clk, .nrst, .usb_enable, .host_mode, .cpu_addr, .cpu_wr, .cpu_rd,
    .cpu_wdata, .cpu_rdata, .usb_irq, .cpu_reset_req, .ep_fifo_hold,
    .link(link));
  usbrb_host #(.FRAME_CYCLES(100), .RESET_CYCLES(10), .RSM_CYCLES(20))
    u_usbrb_host (.sys_clk, .nrst, .cmd_reset, .cmd_resume, .sof_enable,
    .crc_inject, .cmd_setup, .setup_ep_in, .wake_seen, .dev_present,
    .dev_low_spd, .link(link));
  usbrb_checker #(.RESUME_CYCLES(20)) u_usbrb_checker (.sys_clk, .nrst,
    .bus_reset(link.bus_reset), .sof_stb(link.sof_stb),
    .sof_crc_err(link.sof_crc_err), .setup_stb(link.setup_stb),
    .setup_ep(link.setup_ep), .dp_pullup(link.dp_pullup),
    .dm_pullup(link.dm_pullup), .upstream_resume(link.upstream_resume),
    .addr_valid(link.addr_valid), .ep_stall(link.ep_stall),
    .ep_enabled(link.ep_enabled), .toggle_clear(link.toggle_clear));
  // Clock and toggle pulse collector
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    tog_seen <= nrst ? (tog_seen | link.toggle_clear) : 7'h00;
  // Compare, bus cycles and verdict
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk) {cpu_wr, cpu_addr, cpu_wdata} <= {1'b1, a, v};
    @(posedge sys_clk) cpu_wr <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rc(input string nm, input logic [3:0] a,
                    input logic [7:0] m, e);
    @(posedge sys_clk) {cpu_rd, cpu_addr} <= {1'b1, a};
    @(posedge sys_clk) cpu_rd <= 1'b0;
    @(negedge sys_clk) chk(nm, cpu_rdata & m, e);
  endtask
  task automatic hit(input logic [2:0] c);
    @(posedge sys_clk) {cmd_reset, cmd_resume, cmd_setup} <= c;
    @(posedge sys_clk) {cmd_reset, cmd_resume, cmd_setup} <= 3'b000;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic frame();
    @(posedge sys_clk) sof_enable <= 1'b1;
    for (n = 0; n < 300 && link.sof_stb !== 1'b1; n++) @(negedge sys_clk);
    @(posedge sys_clk) sof_enable <= 1'b0;
  endtask
  function automatic logic [7:0] pu();
    return {4'h0, link.dp_pullup, link.dm_pullup, dev_present, dev_low_spd};
  endfunction
  task automatic complete_run();
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    {nrst, usb_enable, host_mode, cpu_wr, cpu_rd, cmd_reset} = 6'b010000;
    {cmd_resume, sof_enable, crc_inject, cmd_setup} = 4'h0;
    {cpu_addr, setup_ep_in, cpu_wdata} = 0;
    bad_count = 0;
    checked = 0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rc("enables", 4'h2, 8'hFF, 8'h08);
    rc("devctl", 4'h0, 8'hFF, 8'h01);
    rc("unmapped", 4'hD, 8'hFF, 8'h00);
    wr(4'h0, 8'h00);
    chk("full speed", pu(), 8'h0A);
    wr(4'h0, 8'h04);
    chk("low speed", pu(), 8'h07);
    @(posedge sys_clk) host_mode <= 1'b1;
    @(negedge sys_clk) chk("host mode", pu(), 8'h00);
    @(posedge sys_clk) host_mode <= 1'b0;
    wr(4'h0, 8'h09);
    chk("detach", pu(), 8'h00);
    wr(4'h3, 8'h05);
    wr(4'h3, 8'h85);
    wr(4'h3, 8'h05);
    chk("addr", {link.addr_valid, link.dev_addr}, 8'h85);
    hit(3'b100);
    for (n = 0; n < 40 && cpu_reset_req !== 1'b1; n++) @(negedge sys_clk);
    chk("cpu reset", cpu_reset_req, 8'h01);
    repeat (2) @(negedge sys_clk);
    chk("irq", usb_irq, 8'h01);
    rc("reset end", 4'h1, 8'h08, 8'h08);
    rc("addr off", 4'h3, 8'h80, 8'h00);
    rc("cpu_reset_on_bus_reset kept", 4'h0, 8'h08, 8'h08);
    wr(4'h1, 8'hFF);
    rc("flag ones", 4'h1, 8'h08, 8'h08);
    wr(4'h1, 8'hF7);
    rc("flag zero", 4'h1, 8'h08, 8'h00);
    chk("irq off", usb_irq, 8'h00);
    hit(3'b001);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h0A);
    rc("wake refused", 4'h0, 8'h02, 8'h00);
    repeat (60) @(negedge sys_clk);
    rc("suspend", 4'h1, 8'h01, 8'h01);
    wr(4'h0, 8'h0A);
    for (n = 0; n < 10 && wake_seen !== 1'b1; n++) @(negedge sys_clk);
    chk("wake seen", wake_seen, 8'h01);
    rc("resume flag", 4'h1, 8'h50, 8'h40);
    repeat (25) @(negedge sys_clk);
    rc("wake done", 4'h0, 8'h02, 8'h00);
    hit(3'b001);
    rc("line wake", 4'h1, 8'h10, 8'h10);
    hit(3'b010);
    repeat (30) @(negedge sys_clk);
    rc("resume end", 4'h1, 8'h20, 8'h20);
    @(posedge sys_clk) crc_inject <= 1'b1;
    @(posedge sys_clk) crc_inject <= 1'b0;
    frame();
    rc("sof", 4'h1, 8'h04, 8'h04);
    rc("crc err", 4'h6, 8'hFF, 8'h10);
    wr(4'h1, 8'hFB);
    frame();
    rc("frame low", 4'h5, 8'hFF, 8'h01);
    rc("frame high", 4'h4, 8'hFF, 8'h00);
    rc("crc clear", 4'h6, 8'hFF, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h41);
    chk("fifo hold", ep_fifo_hold, 8'h41);
    wr(4'h8, 8'h00);
    chk("fifo free", ep_fifo_hold, 8'h00);
    wr(4'h9, 8'h21);
    @(posedge sys_clk) setup_ep_in <= 3'h1;
    hit(3'b001);
    chk("stall", link.ep_stall, 8'h01);
    @(posedge sys_clk) setup_ep_in <= 3'h0;
    hit(3'b001);
    rc("stall setup", 4'h9, 8'hFF, 8'h01);
    wr(4'h9, 8'h21);
    wr(4'h9, 8'h11);
    rc("stall cancel", 4'h9, 8'hFF, 8'h01);
    wr(4'h9, 8'h09);
    rc("toggle", 4'h9, 8'hFF, 8'h01);
    chk("toggle pulse", tog_seen, 8'h01);
    // Type, size and bank codes against capacity
    for (s = 0; s < 8; s++) begin
      wr(4'hA, {s[1:0], 5'h00, s[2]});
      rc("type dir", 4'hA, 8'hFF, {s[1:0], 5'h00, s[2]});
      for (b = 0; b < 3; b++) begin
        wr(4'hB, {1'b0, s[2:0], b[1:0], 2'b10});
        rc("cfg ok", 4'hC, 8'h80,
           {s != 7 && b < 2 && ((8 << s) << b) <= 512, 7'h00});
      end
    end
    wr(4'hB, 8'h00);
    rc("cfg freed", 4'hC, 8'h80, 8'h00);
    wr(4'h7, 8'h07);
    rc("ep none", 4'h9, 8'hFF, 8'h00);
    @(posedge sys_clk) usb_enable <= 1'b0;
    rc("cpu_reset_on_bus_reset off", 4'h0, 8'h08, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
